/* File: hw/occ_pkg.sv */
/*
 * Package of the output channel conditioner: register map, field layout,
 * reset values, timing constants and the carrier types.
 * Assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
// Summary of operation
// - Normal mode: bus bit goes through the conditioning path to the output.
// - Simulation mode: simulation bit replaces the bus bit, same conditioning path.
// - Expired communication watchdog applies the selected error strategy.
// - In normal mode, incoming invalid-data status applies the error strategy like watchdog expiry.
// - Line fault alone never starts the error strategy; output follows its source.
// - Current-value strategy passes the incoming (or simulated) bit unchanged.
// - Substitute strategy drives the substitute bit while the error lasts.
// - Last-valid strategy holds the last value valid before the error.
// - Negation on inverts the logical value before the output.
// - Line fault monitor reports only while its enable is on.
// - Lead breakage or short circuit shows in the channel status.
// - ON delay in ms: rising edge passes only after input stayed high.
// - OFF delay in ms: falling edge is postponed by the set time.
// - Substitute bit is zero or one and always carries invalid status; data_invalid clears one cycle plus any ON/OFF delay before field_out drops it.
// - Simulation bit is zero or one with a valid or invalid status.
// - Invalid simulation status starts the error strategy like bus invalid data.
// - Three failed exchanges, then 500 ms later the output is switched off.
package occ_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS     = 8'h00;
	localparam logic [7:0] ON_DLY_OFS   = 8'h04;
	localparam logic [7:0] OFF_DLY_OFS  = 8'h08;
	localparam logic [7:0] STATUS_OFS   = 8'h0c;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h14;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------------
	// Field layout and reset values
	// ------------------------------------------------------------------
	localparam int DLY_W  = 16;
	localparam int IRQ_W  = 3;
	localparam int IRQ_ERR = 0;
	localparam int IRQ_LF  = 1;
	localparam int IRQ_OFF = 2;

	typedef enum logic [1:0] {
		OCC_STRAT_CUR   = 2'b00,
		OCC_STRAT_SUBST = 2'b01,
		OCC_STRAT_LAST  = 2'b10,
		OCC_STRAT_RSVD  = 2'b11
	} occ_strat_t;

	typedef struct packed {
		logic       sim_invalid;
		logic       sim_bit;
		logic       subst_bit;
		logic       lf_en;
		logic       negate;
		occ_strat_t strat;
		logic       sim_mode;
	} occ_cfg_t;

	typedef struct packed {
		logic last_valid;
		logic mod_off;
		logic err_active;
		logic line_fault;
		logic data_invalid;
		logic field_out;
	} occ_stat_t;

	localparam logic [7:0]       CTRL_RST    = 8'h10;
	localparam logic [DLY_W-1:0] DLY_RST     = 16'h0000;
	localparam logic [IRQ_W-1:0] IRQ_RST     = 3'h0;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int MS_NS         = 1000000;
	localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
	localparam int TICK_W        = 18;
	localparam int WD_OFF_MS     = 500;
	localparam int WD_FAILS      = 3;
	localparam int WD_W          = 10;

endpackage : occ_pkg

/* File: hw/occ_ms_tick.sv */
/*
 * Millisecond enable generator: one-cycle pulse every CYC_PER_MS clocks.
 * Assumes one system clock; the count is shortened in simulation via the
 * parameter.
 */
`timescale 1ns/1ps
`default_nettype none
module occ_ms_tick #(
	parameter int CYC_PER_MS = occ_pkg::CYC_PER_MS
) (
	input  wire logic mclk,
	input  wire logic sys_rst,
	output var  logic tick
);
	logic [occ_pkg::TICK_W-1:0] cnt_reg;
	logic [occ_pkg::TICK_W-1:0] cnt_next;
	logic                       tick_next;

	always_comb begin
		tick_next = 1'b0;
		cnt_next  = cnt_reg + 1'b1;
		if (cnt_reg == occ_pkg::TICK_W'(CYC_PER_MS - 1)) begin
			cnt_next  = '0;
			tick_next = 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_reg <= '0;
			tick    <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tick    <= tick_next;
		end
	end

	a_tick_period: assert property (@(posedge mclk) disable iff (sys_rst)
		tick |=> !tick) else $error("ms tick lasted more than one cycle");

endmodule // occ_ms_tick
`default_nettype wire

/* File: hw/occ_delay.sv */
/*
 * ON/OFF delay filter counted in millisecond ticks.
 * Assumes a one-cycle ms enable; the first ms may be short by up to one
 * tick period because the tick is free running.
 */
`timescale 1ns/1ps
`default_nettype none
module occ_delay (
	input  wire logic                      mclk,
	input  wire logic                      sys_rst,
	input  wire logic                      tick,
	input  wire logic                      din,
	input  wire logic [occ_pkg::DLY_W-1:0] on_dly,
	input  wire logic [occ_pkg::DLY_W-1:0] off_dly,
	output var  logic                      dout
);
	logic [occ_pkg::DLY_W-1:0] cnt_reg;
	logic [occ_pkg::DLY_W-1:0] cnt_next;
	logic                      dout_next;
	logic [occ_pkg::DLY_W-1:0] lim;

	// A change that reverts before its delay ran out is dropped, so short
	// pulses vanish on the ON side and gaps vanish on the OFF side.
	always_comb begin
		lim       = din ? on_dly : off_dly;
		dout_next = dout;
		cnt_next  = '0;
		if (din != dout) begin
			if (lim == '0) begin
				dout_next = din;
			end else if (tick && (cnt_reg + 1'b1 >= lim)) begin
				dout_next = din;
			end else if (tick) begin
				cnt_next = cnt_reg + 1'b1;
			end else begin
				cnt_next = cnt_reg;
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_reg <= '0;
			dout    <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			dout    <= dout_next;
		end
	end

	a_on_needs_time: assert property (@(posedge mclk) disable iff (sys_rst)
		$rose(dout) && on_dly != '0 |-> $past(tick)) else $error("rise without ON delay");
	a_off_postponed: assert property (@(posedge mclk) disable iff (sys_rst)
		$fell(dout) && off_dly != '0 |-> $past(tick)) else $error("fall without OFF delay");

endmodule // occ_delay
`default_nettype wire

/* File: hw/occ_top.sv */
/*
 * Output channel conditioner for one digital output: source selection,
 * error strategy, negation, ON/OFF delays, line fault status, module
 * watchdog, interrupt and AXI4-Lite register slave.
 * Assumes all inputs synchronous to mclk; wd_expired, line_fault_in and
 * the exchange pulses come from surrounding logic.
 */
`timescale 1ns/1ps
`default_nettype none
module occ_top #(
	parameter int CYC_PER_MS = occ_pkg::CYC_PER_MS
) (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        bus_bit,
	input  wire logic        bus_invalid,
	input  wire logic        wd_expired,
	input  wire logic        line_fault_in,
	input  wire logic        comm_fail,
	input  wire logic        comm_ok,
	output var  logic        field_out,
	output var  logic        data_invalid,
	output var  logic        line_fault,
	output var  logic        irq
);
	// ------------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------------
	occ_pkg::occ_cfg_t                 cfg_reg,      cfg_next;
	logic [occ_pkg::DLY_W-1:0]         on_dly_reg,   on_dly_next;
	logic [occ_pkg::DLY_W-1:0]         off_dly_reg,  off_dly_next;
	logic [occ_pkg::IRQ_W-1:0]         istat_reg,    istat_next;
	logic [occ_pkg::IRQ_W-1:0]         imask_reg,    imask_next;
	logic                              aw_full_reg,  aw_full_next;
	logic                              w_full_reg,   w_full_next;
	logic [7:0]                        awaddr_reg,   awaddr_next;
	logic [31:0]                       wdata_reg,    wdata_next;
	logic [3:0]                        wstrb_reg,    wstrb_next;
	logic                              bvalid_next;
	logic [1:0]                        bresp_next;
	logic                              rvalid_next;
	logic [1:0]                        rresp_next;
	logic [31:0]                       rdata_next;
	logic                              do_write;
	logic [occ_pkg::IRQ_W-1:0]         w1c;
	logic [31:0]                       mg_cfg, mg_on, mg_off;

	// ------------------------------------------------------------------
	// Channel state
	// ------------------------------------------------------------------
	logic                              sel_reg,      sel_next;
	logic                              err_reg,      err_next;
	logic                              last_reg,     last_next;
	logic                              inv_reg,      inv_next;
	logic                              lf_reg,       lf_next;
	logic                              off_reg,      off_next;
	logic [1:0]                        fails_reg,    fails_next;
	logic [occ_pkg::WD_W-1:0]          wdcnt_reg,    wdcnt_next;
	logic                              fout_next;
	logic                              irq_next;
	logic                              src_bit;
	logic                              src_inval;
	logic                              err_now;
	logic                              strat_bit;
	logic                              filt_out;
	logic                              ms_tick;
	occ_pkg::occ_stat_t                stat;
	logic [occ_pkg::IRQ_W-1:0]         ev;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == occ_pkg::CTRL_OFS) || (a == occ_pkg::ON_DLY_OFS) ||
			(a == occ_pkg::OFF_DLY_OFS) || (a == occ_pkg::STATUS_OFS) ||
			(a == occ_pkg::IRQ_STAT_OFS) || (a == occ_pkg::IRQ_MASK_OFS);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
		end
	endfunction

	// ------------------------------------------------------------------
	// Source selection and error strategy
	// ------------------------------------------------------------------
	always_comb begin
		src_bit   = cfg_reg.sim_mode ? cfg_reg.sim_bit : bus_bit;
		src_inval = cfg_reg.sim_mode ? cfg_reg.sim_invalid : bus_invalid;
		// Line fault deliberately left out of the error term.
		err_now   = wd_expired || src_inval;
		case (cfg_reg.strat)
			occ_pkg::OCC_STRAT_SUBST: strat_bit = err_now ? cfg_reg.subst_bit : src_bit;
			occ_pkg::OCC_STRAT_LAST:  strat_bit = err_now ? last_reg : src_bit;
			default:                  strat_bit = src_bit;
		endcase
		last_next = err_now ? last_reg : src_bit;
		// Negation sits after the strategy and before the delays.
		sel_next  = strat_bit ^ cfg_reg.negate;
		err_next  = err_now;
		// Every strategy reports invalid data during an error; data_invalid clears one
		// cycle plus any ON/OFF delay before field_out drops the substitute bit.
		inv_next  = err_now;
		lf_next   = cfg_reg.lf_en && line_fault_in;
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			sel_reg  <= 1'b0;
			err_reg  <= 1'b0;
			last_reg <= 1'b0;
			inv_reg  <= 1'b0;
			lf_reg   <= 1'b0;
		end else begin
			sel_reg  <= sel_next;
			err_reg  <= err_next;
			last_reg <= last_next;
			inv_reg  <= inv_next;
			lf_reg   <= lf_next;
		end
	end

	// ------------------------------------------------------------------
	// Delays and module watchdog
	// ------------------------------------------------------------------
	occ_ms_tick #(.CYC_PER_MS(CYC_PER_MS)) u_tick (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.tick    (ms_tick)
	);

	occ_delay u_delay (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.tick    (ms_tick),
		.din     (sel_reg),
		.on_dly  (on_dly_reg),
		.off_dly (off_dly_reg),
		.dout    (filt_out)
	);

	// A good exchange clears the failure run and restores the output.
	always_comb begin
		fails_next = fails_reg;
		wdcnt_next = wdcnt_reg;
		off_next   = off_reg;
		if (comm_ok) begin
			fails_next = '0;
			wdcnt_next = '0;
			off_next   = 1'b0;
		end else begin
			if (comm_fail && fails_reg != 2'(occ_pkg::WD_FAILS)) begin
				fails_next = fails_reg + 1'b1;
			end
			if (fails_reg == 2'(occ_pkg::WD_FAILS) && !off_reg && ms_tick) begin
				wdcnt_next = wdcnt_reg + 1'b1;
				if (wdcnt_reg == occ_pkg::WD_W'(occ_pkg::WD_OFF_MS - 1)) begin
					off_next = 1'b1;
				end
			end
		end
		fout_next = filt_out && !off_reg;
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			fails_reg    <= '0;
			wdcnt_reg    <= '0;
			off_reg      <= 1'b0;
			field_out    <= 1'b0;
			data_invalid <= 1'b0;
			line_fault   <= 1'b0;
		end else begin
			fails_reg    <= fails_next;
			wdcnt_reg    <= wdcnt_next;
			off_reg      <= off_next;
			field_out    <= fout_next;
			data_invalid <= inv_reg;
			line_fault   <= lf_reg;
		end
	end

	// ------------------------------------------------------------------
	// Interrupts and AXI4-Lite slave
	// ------------------------------------------------------------------
	always_comb begin
		stat = '{last_valid: last_reg, mod_off: off_reg, err_active: err_reg,
			line_fault: lf_reg, data_invalid: inv_reg, field_out: field_out};
		ev   = {off_next && !off_reg, lf_next && !lf_reg, err_next && !err_reg};
	end

	always_comb begin
		aw_full_next = aw_full_reg;
		w_full_next  = w_full_reg;
		awaddr_next  = awaddr_reg;
		wdata_next   = wdata_reg;
		wstrb_next   = wstrb_reg;
		bvalid_next  = s_axi_bvalid && !s_axi_bready;
		bresp_next   = s_axi_bresp;
		rvalid_next  = s_axi_rvalid && !s_axi_rready;
		rresp_next   = s_axi_rresp;
		rdata_next   = s_axi_rdata;
		cfg_next     = cfg_reg;
		on_dly_next  = on_dly_reg;
		off_dly_next = off_dly_reg;
		imask_next   = imask_reg;
		w1c          = '0;
		mg_cfg       = merge(32'(cfg_reg), wdata_reg, wstrb_reg);
		mg_on        = merge(32'(on_dly_reg), wdata_reg, wstrb_reg);
		mg_off       = merge(32'(off_dly_reg), wdata_reg, wstrb_reg);
		if (s_axi_awvalid && s_axi_awready) begin
			aw_full_next = 1'b1;
			awaddr_next  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_full_next = 1'b1;
			wdata_next  = s_axi_wdata;
			wstrb_next  = s_axi_wstrb;
		end
		do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
		if (do_write) begin
			aw_full_next = 1'b0;
			w_full_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = mapped(awaddr_reg) ? occ_pkg::RESP_OKAY : occ_pkg::RESP_SLVERR;
			case (awaddr_reg)
				occ_pkg::CTRL_OFS:     cfg_next = occ_pkg::occ_cfg_t'(mg_cfg[7:0]);
				occ_pkg::ON_DLY_OFS:   on_dly_next = mg_on[15:0];
				occ_pkg::OFF_DLY_OFS:  off_dly_next = mg_off[15:0];
				occ_pkg::IRQ_STAT_OFS: w1c = wstrb_reg[0] ? wdata_reg[2:0] : '0;
				occ_pkg::IRQ_MASK_OFS: imask_next = wstrb_reg[0] ? wdata_reg[2:0] : imask_reg;
				default:               w1c = '0;
			endcase
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_next = 1'b1;
			rresp_next  = mapped(s_axi_araddr) ? occ_pkg::RESP_OKAY : occ_pkg::RESP_SLVERR;
			case (s_axi_araddr)
				occ_pkg::CTRL_OFS:     rdata_next = 32'(cfg_reg);
				occ_pkg::ON_DLY_OFS:   rdata_next = 32'(on_dly_reg);
				occ_pkg::OFF_DLY_OFS:  rdata_next = 32'(off_dly_reg);
				occ_pkg::STATUS_OFS:   rdata_next = 32'(stat);
				occ_pkg::IRQ_STAT_OFS: rdata_next = 32'(istat_reg);
				occ_pkg::IRQ_MASK_OFS: rdata_next = 32'(imask_reg);
				default:               rdata_next = '0;
			endcase
		end
		// A new event in the clearing cycle survives the clear.
		istat_next = (istat_reg & ~w1c) | ev;
		irq_next   = |(istat_next & imask_next);
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_reg       <= occ_pkg::CTRL_RST;
			on_dly_reg    <= occ_pkg::DLY_RST;
			off_dly_reg   <= occ_pkg::DLY_RST;
			istat_reg     <= occ_pkg::IRQ_RST;
			imask_reg     <= occ_pkg::IRQ_RST;
			aw_full_reg   <= 1'b0;
			w_full_reg    <= 1'b0;
			awaddr_reg    <= '0;
			wdata_reg     <= '0;
			wstrb_reg     <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= occ_pkg::RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= occ_pkg::RESP_OKAY;
			s_axi_rdata   <= '0;
			irq           <= 1'b0;
		end else begin
			cfg_reg       <= cfg_next;
			on_dly_reg    <= on_dly_next;
			off_dly_reg   <= off_dly_next;
			istat_reg     <= istat_next;
			imask_reg     <= imask_next;
			aw_full_reg   <= aw_full_next;
			w_full_reg    <= w_full_next;
			awaddr_reg    <= awaddr_next;
			wdata_reg     <= wdata_next;
			wstrb_reg     <= wstrb_next;
			s_axi_awready <= !aw_full_next && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_full_next && !(s_axi_wvalid && s_axi_wready);
			s_axi_bvalid  <= bvalid_next;
			s_axi_bresp   <= bresp_next;
			s_axi_arready <= !rvalid_next && !(s_axi_arvalid && s_axi_arready);
			s_axi_rvalid  <= rvalid_next;
			s_axi_rresp   <= rresp_next;
			s_axi_rdata   <= rdata_next;
			irq           <= irq_next;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	a_normal_path: assert property (@(posedge mclk) disable iff (sys_rst)
		!cfg_reg.sim_mode && !wd_expired && !bus_invalid
		|=> sel_reg == ($past(bus_bit) ^ $past(cfg_reg.negate)))
		else $error("normal path does not follow bus bit");
	a_sim_path: assert property (@(posedge mclk) disable iff (sys_rst)
		cfg_reg.sim_mode && !cfg_reg.sim_invalid && !wd_expired
		|=> sel_reg == ($past(cfg_reg.sim_bit) ^ $past(cfg_reg.negate)))
		else $error("simulation path does not follow simulation bit");
	a_wd_error: assert property (@(posedge mclk) disable iff (sys_rst)
		wd_expired |=> err_reg && data_invalid == $past(err_reg))
		else $error("watchdog expiry not flagged as error");
	a_sim_invalid: assert property (@(posedge mclk) disable iff (sys_rst)
		cfg_reg.sim_mode && cfg_reg.sim_invalid |=> err_reg)
		else $error("invalid simulation status not treated as error");
	a_cur_value: assert property (@(posedge mclk) disable iff (sys_rst)
		cfg_reg.strat == occ_pkg::OCC_STRAT_CUR && err_now
		|=> sel_reg == ($past(src_bit) ^ $past(cfg_reg.negate)))
		else $error("current value not passed during error");
	a_sub_value: assert property (@(posedge mclk) disable iff (sys_rst)
		cfg_reg.strat == occ_pkg::OCC_STRAT_SUBST && err_now
		|=> sel_reg == ($past(cfg_reg.subst_bit) ^ $past(cfg_reg.negate)) ##1 data_invalid)
		else $error("substitute value or its invalid status missing");
	a_last_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		err_now && $past(err_now) |-> last_reg == $past(last_reg))
		else $error("last valid value changed during error");
	a_lf_gate: assert property (@(posedge mclk) disable iff (sys_rst)
		!cfg_reg.lf_en [*2] |=> !line_fault)
		else $error("line fault reported while monitor off");
	a_lf_no_err: assert property (@(posedge mclk) disable iff (sys_rst)
		line_fault_in && !wd_expired && !src_inval |=> !err_reg)
		else $error("line fault started the error strategy");
	a_off_time: assert property (@(posedge mclk) disable iff (sys_rst)
		$rose(off_reg) |-> $past(wdcnt_reg) == occ_pkg::WD_W'(occ_pkg::WD_OFF_MS - 1))
		else $error("output switched off at wrong time");
	a_off_forces: assert property (@(posedge mclk) disable iff (sys_rst)
		off_reg |=> !field_out)
		else $error("output driven while module watchdog off");

endmodule // occ_top
`default_nettype wire

/* File: verif/occ_com_model.sv */
/*
 * Model of the communication unit: presents the received bit with its
 * validity and reports each exchange as a one-cycle pulse.
 * Assumes the bench toggles a request line once per exchange.
 */
`timescale 1ns/1ps
`default_nettype none
module occ_com_model (
	input  wire logic mclk,
	input  wire logic sys_rst,
	input  wire logic tx_bit,
	input  wire logic tx_inv,
	input  wire logic fail_tgl,
	input  wire logic ok_tgl,
	output var  logic bus_bit,
	output var  logic bus_invalid,
	output var  logic comm_fail,
	output var  logic comm_ok
);
	logic f_q;
	logic o_q;
	// Toggles become pulses, so two exchanges never merge into one.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			{bus_bit, bus_invalid, comm_fail, comm_ok, f_q, o_q} <= '0;
		end else begin
			bus_bit     <= tx_bit;
			bus_invalid <= tx_inv;
			comm_fail   <= fail_tgl ^ f_q;
			comm_ok     <= ok_tgl ^ o_q;
			f_q         <= fail_tgl;
			o_q         <= ok_tgl;
		end
	end
endmodule // occ_com_model
`default_nettype wire

/* File: verif/tb.sv */
/*
 * Self-checking bench of the output channel conditioner.
 * Assumes the millisecond count is shortened to MS clocks.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int MS = 10;
	logic        mclk = '0, sys_rst = '1, tx_bit = '0, tx_inv = '0, fail_tgl = '0, ok_tgl = '0;
	logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
	logic        s_axi_rready = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, wd_expired = '0, line_fault_in = '0, bus_bit, bus_invalid;
	logic        comm_fail, comm_ok, field_out, data_invalid, line_fault, irq;
	int          n_errors = 0, n_compared = 0;
	occ_com_model PM (.mclk, .sys_rst, .tx_bit, .tx_inv, .fail_tgl, .ok_tgl, .bus_bit,
		.bus_invalid, .comm_fail, .comm_ok);
	occ_top #(.CYC_PER_MS(MS)) DUT (.mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.bus_bit, .bus_invalid, .wd_expired, .line_fault_in, .comm_fail, .comm_ok,
		.field_out, .data_invalid, .line_fault, .irq);
	initial begin
		forever #2.5 mclk = ~mclk;
	end
	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task close_out;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task w(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// Handshakes are judged at the falling edge so the taking edge is known.
	task wr(input logic [7:0] a, input logic [31:0] v);
		int i;
		logic ta, tw, bv;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (i = 0; i < 40; i++) begin
			@(negedge mclk);
			{ta, tw, bv, r} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
			@(posedge mclk);
			if (ta) s_axi_awvalid <= '0;
			if (tw) s_axi_wvalid <= '0;
			if (bv) break;
		end
		s_axi_bready <= '0;
		if (i == 40) n_errors++;
		if (i == 40) close_out();
	endtask
	task rd(input logic [7:0] a);
		int i;
		logic ta, rv;
		@(posedge mclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		for (i = 0; i < 40; i++) begin
			@(negedge mclk);
			{ta, rv, d, r} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
			@(posedge mclk);
			if (ta) s_axi_arvalid <= '0;
			if (rv) break;
		end
		s_axi_rready <= '0;
		if (i == 40) n_errors++;
		if (i == 40) close_out();
	endtask
	task setp(input logic b, input logic [31:0] c);
		wr(occ_pkg::CTRL_OFS, c);
		@(posedge mclk);
		tx_bit <= b;
		w(6);
	endtask
	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task t_regs;
		rd(occ_pkg::CTRL_OFS);
		chk(d, 32'h10);
		rd(8'h18);
		chk({d[29:0], r}, {30'h0, occ_pkg::RESP_SLVERR});
		wr(8'h18, 32'h1);
		chk(r, occ_pkg::RESP_SLVERR);
		wr(occ_pkg::ON_DLY_OFS, 32'h5);
		chk(r, occ_pkg::RESP_OKAY);
		rd(occ_pkg::ON_DLY_OFS);
		chk(d, 32'h5);
		wr(occ_pkg::ON_DLY_OFS, 32'h0);
	endtask
	task t_path;
		setp(1, 32'h10);
		chk(field_out, 1);
		setp(1, 32'h18);
		chk(field_out, 0);
		setp(0, 32'h18);
		chk(field_out, 1);
		setp(0, 32'h51);
		chk({data_invalid, field_out}, 2'h1);
		setp(1, 32'hd3);
		chk({data_invalid, field_out}, 2'h2);
	endtask
	// Source held at one, then zero arrives with the error: current gives zero, last valid gives one, substitute gives its bit.
	task t_err;
		for (int s = 0; s < 3; s++) begin
			for (int b = 0; b < 2; b++) begin
				setp(1, 32'h10 | (s << 1) | (b << 5));
				@(posedge mclk);
				tx_bit <= '0;
				wd_expired <= b[0];
				tx_inv <= !b[0];
				w(6);
				chk(field_out, s == 0 ? 0 : (s == 1 ? b : 1));
				chk(data_invalid, 1);
				@(posedge mclk);
				{wd_expired, tx_inv} <= 2'h0;
				w(6);
				chk(data_invalid, 0);
			end
		end
	endtask
	task t_lf;
		setp(1, 32'h10);
		@(posedge mclk);
		line_fault_in <= '1;
		w(6);
		chk({line_fault, field_out, data_invalid, irq}, 4'hc);
		rd(occ_pkg::STATUS_OFS);
		chk(d, 32'h25);
		wr(occ_pkg::IRQ_MASK_OFS, 32'h2);
		w(2);
		chk(irq, 1);
		wr(occ_pkg::IRQ_STAT_OFS, 32'h7);
		w(2);
		chk(irq, 0);
		setp(1, 32'h00);
		chk(line_fault, 0);
		@(posedge mclk);
		line_fault_in <= '0;
	endtask
	// A short pulse must vanish; a held level passes late in both directions.
	task t_dly;
		wr(occ_pkg::ON_DLY_OFS, 32'h3);
		wr(occ_pkg::OFF_DLY_OFS, 32'h3);
		setp(0, 32'h10);
		@(posedge mclk);
		tx_bit <= '1;
		repeat (8) @(posedge mclk);
		tx_bit <= '0;
		w(40);
		chk(field_out, 0);
		setp(1, 32'h10);
		chk(field_out, 0);
		w(46);
		chk(field_out, 1);
		setp(0, 32'h10);
		chk(field_out, 1);
		w(46);
		chk(field_out, 0);
		wr(occ_pkg::ON_DLY_OFS, 32'h0);
		wr(occ_pkg::OFF_DLY_OFS, 32'h0);
	endtask
	task t_wd;
		setp(1, 32'h10);
		repeat (3) begin
			@(posedge mclk);
			fail_tgl <= ~fail_tgl;
			w(3);
		end
		w(400 * MS);
		chk(field_out, 1);
		w(150 * MS);
		chk(field_out, 0);
		@(posedge mclk);
		ok_tgl <= ~ok_tgl;
		w(6);
		chk(field_out, 1);
	endtask
	initial begin
		repeat (5) @(posedge mclk);
		sys_rst <= '0;
		t_regs();
		t_path();
		t_err();
		t_lf();
		t_dly();
		t_wd();
		close_out();
	end
endmodule // tb
`default_nettype wire
